// >>> cra_pkg.sv
// package: register offsets, reset values, field positions and carrier types
package cra_pkg;
    // ***************************************************************
    // special register offsets
    // ***************************************************************
    localparam logic [7:0] SFR_STACK_POINTER = 8'h81;
    localparam logic [7:0] SFR_DATA_POINTER_LOW = 8'h82;
    localparam logic [7:0] SFR_DATA_POINTER_HIGH = 8'h83;
    localparam logic [7:0] SFR_PROGRAM_STATUS_WORD = 8'hD0;
    localparam logic [7:0] SFR_ARITH_MAIN_OPERAND = 8'hE0;
    localparam logic [7:0] SFR_SECOND_OPERAND_REG = 8'hF0;
    // ***************************************************************
    // reset values
    // ***************************************************************
    localparam logic [7:0] RST_STACK_POINTER = 8'h07;
    localparam logic [7:0] RST_ZERO_BYTE = 8'h00;
    // ***************************************************************
    // status word bit positions
    // ***************************************************************
    localparam int PSW_CARRY = 7;
    localparam int PSW_AUX_CARRY = 6;
    localparam int PSW_USER_ZERO = 5;
    localparam int PSW_BANK_HI = 4;
    localparam int PSW_BANK_LO = 3;
    localparam int PSW_RANGE_ERR = 2;
    localparam int PSW_USER_ONE = 1;
    localparam int PSW_PARITY = 0;
    // ***************************************************************
    // memory layout
    // ***************************************************************
    localparam logic [7:0] UPPER_AREA_BASE = 8'h80;
    localparam int RAM_DEPTH = 256;
    localparam int BANK_REGS = 8;
    localparam logic [1:0] INDEX_WORK_ZERO = 2'h0;
    localparam logic [1:0] INDEX_WORK_ONE = 2'h1;
    localparam logic [1:0] INDEX_STACK = 2'h2;
    // ***************************************************************
    // operand addressing modes
    // ***************************************************************
    typedef enum logic [2:0] {
        CRA_MODE_DIRECT,
        CRA_MODE_INDIRECT8,
        CRA_MODE_INDIRECT16,
        CRA_MODE_REGISTER,
        CRA_MODE_SPECIFIC,
        CRA_MODE_IMMEDIATE,
        CRA_MODE_INDEXED
    } cra_mode_type;
    // implied operand for register-specific mode
    typedef enum logic [1:0] {
        CRA_IMPLY_ACC,
        CRA_IMPLY_SECOND,
        CRA_IMPLY_POINTER_LOW,
        CRA_IMPLY_POINTER_HIGH
    } cra_imply_type;
    // operand request from the decoder
    typedef struct packed {
        logic valid;
        cra_mode_type mode;
        logic [7:0] addr_field;
        logic [2:0] reg_field;
        logic [1:0] indir_src;
        logic use_pc_base;
        logic [15:0] pc;
        logic [7:0] imm_byte;
        cra_imply_type imply;
    } cra_req_type;
    // resolved operand
    typedef struct packed {
        logic valid;
        logic is_sfr;
        logic is_code;
        logic is_value;
        logic [15:0] addr;
        logic [7:0] value;
    } cra_res_type;
    // write from the execution unit, to a special register or to RAM
    typedef struct packed {
        logic valid;
        logic is_sfr;
        logic [7:0] addr;
        logic [7:0] data;
    } cra_wr_type;
    // flag, accumulator and second operand updates from the arithmetic unit
    typedef struct packed {
        logic carry_we;
        logic carry;
        logic aux_we;
        logic aux;
        logic range_we;
        logic range;
        logic acc_we;
        logic [7:0] acc;
        logic second_we;
        logic [7:0] second;
    } cra_alu_type;
endpackage

// >>> cra_regs.sv
// file: program-visible register set and operand address resolution
`timescale 1ns/10ps
// ***************************************************************
// Overview of operation
// ***************************************************************
module cra_regs (
    input wire logic clk_sys,
    input wire logic rst,
    input cra_pkg::cra_req_type req,
    output cra_pkg::cra_res_type res,
    input cra_pkg::cra_wr_type wr,
    input wire logic push,
    input wire logic [7:0] push_data,
    input wire logic pop,
    input cra_pkg::cra_alu_type alu,
    input wire logic bit_carry_we,
    input wire logic bit_carry,
    input wire logic [7:0] sfr_rd_addr,
    output logic [7:0] sfr_rd_data,
    input wire logic [7:0] ram_rd_addr,
    output logic [7:0] ram_rd_data,
    input wire logic jump_req,
    output logic [15:0] jump_target,
    output logic [7:0] status_word,
    output logic [7:0] stack_top,
    output logic [15:0] pointer_value
);
    logic [7:0] stack_pointer;
    logic [7:0] data_pointer_low;
    logic [7:0] data_pointer_high;
    logic [7:0] arith_main_operand;
    logic [7:0] second_operand_reg;
    logic carry_flag;
    logic aux_carry_flag;
    logic user_flag_zero;
    logic bank_select_hi;
    logic bank_select_lo;
    logic signed_range_error_flag;
    logic user_flag_one;
    logic parity_flag;
    logic [7:0] ram [cra_pkg::RAM_DEPTH];
    logic [1:0] bank;
    logic [7:0] work_reg_zero;
    logic [7:0] work_reg_one;
    logic [15:0] sixteen_bit_pointer;
    logic [7:0] next_stack_pointer;
    logic sfr_wr;
    logic ram_wr;
    logic [7:0] ram_wr_addr;
    logic [7:0] ram_wr_data;
    logic psw_wr;
    logic [15:0] index_base;
    // pointer registers sit in slots zero and one of the selected bank
    localparam logic [2:0] SLOT_WORK_ZERO = 3'h0;
    localparam logic [2:0] SLOT_WORK_ONE = 3'h1;

    // ***************************************************************
    // bank and pointer views
    // ***************************************************************
    assign bank = {bank_select_hi, bank_select_lo};
    // bank base is bank times eight inside the lowest 32 bytes
    assign work_reg_zero = ram[{3'h0, bank, SLOT_WORK_ZERO}];
    assign work_reg_one = ram[{3'h0, bank, SLOT_WORK_ONE}];
    assign sixteen_bit_pointer = {data_pointer_high,
        data_pointer_low};
    assign parity_flag = ^arith_main_operand;
    assign sfr_wr = wr.valid & wr.is_sfr;
    assign psw_wr = sfr_wr && wr.addr == cra_pkg::SFR_PROGRAM_STATUS_WORD;
    assign next_stack_pointer = 8'(stack_pointer + 8'h01);
    assign index_base = req.use_pc_base ? req.pc : sixteen_bit_pointer;

    // ***************************************************************
    // stack pointer
    // ***************************************************************
    // push increments first, then writes at the new location
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stack_pointer <= cra_pkg::RST_STACK_POINTER;
        end else if (push) begin
            stack_pointer <= next_stack_pointer;
        end else if (pop) begin
            stack_pointer <= 8'(stack_pointer - 8'h01);
        end else if (sfr_wr && wr.addr == cra_pkg::SFR_STACK_POINTER) begin
            stack_pointer <= wr.data;
        end
    end

    // ***************************************************************
    // data pointer
    // ***************************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            data_pointer_low <= cra_pkg::RST_ZERO_BYTE;
            data_pointer_high <= cra_pkg::RST_ZERO_BYTE;
        end else if (sfr_wr) begin
            if (wr.addr == cra_pkg::SFR_DATA_POINTER_LOW) begin
                data_pointer_low <= wr.data;
            end
            if (wr.addr == cra_pkg::SFR_DATA_POINTER_HIGH) begin
                data_pointer_high <= wr.data;
            end
        end
    end

    // ***************************************************************
    // accumulator and second operand
    // ***************************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            arith_main_operand <= cra_pkg::RST_ZERO_BYTE;
        end else if (alu.acc_we) begin
            arith_main_operand <= alu.acc;
        end else if (sfr_wr
                && wr.addr == cra_pkg::SFR_ARITH_MAIN_OPERAND) begin
            arith_main_operand <= wr.data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            second_operand_reg <= cra_pkg::RST_ZERO_BYTE;
        end else if (alu.second_we) begin
            second_operand_reg <= alu.second;
        end else if (sfr_wr
                && wr.addr == cra_pkg::SFR_SECOND_OPERAND_REG) begin
            second_operand_reg <= wr.data;
        end
    end

    // ***************************************************************
    // status word
    // ***************************************************************
    // hardware flag updates win over a software write in the same cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            carry_flag <= 1'b0;
        end else if (bit_carry_we) begin
            carry_flag <= bit_carry;
        end else if (alu.carry_we) begin
            carry_flag <= alu.carry;
        end else if (psw_wr) begin
            carry_flag <= wr.data[cra_pkg::PSW_CARRY];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            aux_carry_flag <= 1'b0;
        end else if (alu.aux_we) begin
            aux_carry_flag <= alu.aux;
        end else if (psw_wr) begin
            aux_carry_flag <= wr.data[cra_pkg::PSW_AUX_CARRY];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            signed_range_error_flag <= 1'b0;
        end else if (alu.range_we) begin
            signed_range_error_flag <= alu.range;
        end else if (psw_wr) begin
            signed_range_error_flag <= wr.data[cra_pkg::PSW_RANGE_ERR];
        end
    end

    // user flags and bank select change only by software
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            user_flag_zero <= 1'b0;
            bank_select_hi <= 1'b0;
            bank_select_lo <= 1'b0;
            user_flag_one <= 1'b0;
        end else if (psw_wr) begin
            user_flag_zero <= wr.data[cra_pkg::PSW_USER_ZERO];
            bank_select_hi <= wr.data[cra_pkg::PSW_BANK_HI];
            bank_select_lo <= wr.data[cra_pkg::PSW_BANK_LO];
            user_flag_one <= wr.data[cra_pkg::PSW_USER_ONE];
        end
    end

    assign status_word = {carry_flag, aux_carry_flag, user_flag_zero,
        bank_select_hi, bank_select_lo, signed_range_error_flag,
        user_flag_one, parity_flag};

    // ***************************************************************
    // internal data RAM
    // ***************************************************************
    // non-special writes land in RAM unless a push in the same cycle takes the port; pushes at the incremented pointer
    assign ram_wr = push | (wr.valid & ~wr.is_sfr);
    assign ram_wr_addr = push ? next_stack_pointer : wr.addr;
    assign ram_wr_data = push ? push_data : wr.data;

    always_ff @(posedge clk_sys) begin
        if (ram_wr) begin
            ram[ram_wr_addr] <= ram_wr_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ram_rd_data <= cra_pkg::RST_ZERO_BYTE;
        end else begin
            ram_rd_data <= ram[ram_rd_addr];
        end
    end

    // ***************************************************************
    // special register read port
    // ***************************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sfr_rd_data <= cra_pkg::RST_ZERO_BYTE;
        end else begin
            case (sfr_rd_addr)
                cra_pkg::SFR_STACK_POINTER: sfr_rd_data <= stack_pointer;
                cra_pkg::SFR_DATA_POINTER_LOW: sfr_rd_data <= data_pointer_low;
                cra_pkg::SFR_DATA_POINTER_HIGH: begin
                    sfr_rd_data <= data_pointer_high;
                end
                cra_pkg::SFR_PROGRAM_STATUS_WORD: sfr_rd_data <= status_word;
                cra_pkg::SFR_ARITH_MAIN_OPERAND: begin
                    sfr_rd_data <= arith_main_operand;
                end
                cra_pkg::SFR_SECOND_OPERAND_REG: begin
                    sfr_rd_data <= second_operand_reg;
                end
                default: sfr_rd_data <= cra_pkg::RST_ZERO_BYTE;
            endcase
        end
    end

    // ***************************************************************
    // operand resolution, one registered stage of the pipeline
    // ***************************************************************
    // each request is resolved in one clock, no machine cycle grouping
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            res <= '0;
        end else if (!req.valid) begin
            res <= '0;
        end else begin
            res <= '0;
            res.valid <= req.valid;
            case (req.mode)
                cra_pkg::CRA_MODE_DIRECT: begin
                    res.addr <= {8'h00, req.addr_field};
                    res.is_sfr <= req.addr_field
                        >= cra_pkg::UPPER_AREA_BASE;
                end
                cra_pkg::CRA_MODE_INDIRECT8: begin
                    // always RAM, including the upper 128 bytes
                    case (req.indir_src)
                        cra_pkg::INDEX_WORK_ZERO: begin
                            res.addr <= {8'h00, work_reg_zero};
                        end
                        cra_pkg::INDEX_WORK_ONE: begin
                            res.addr <= {8'h00, work_reg_one};
                        end
                        cra_pkg::INDEX_STACK: begin
                            res.addr <= {8'h00, stack_pointer};
                        end
                        default: res.addr <= {8'h00, work_reg_zero};
                    endcase
                end
                cra_pkg::CRA_MODE_INDIRECT16: begin
                    res.addr <= sixteen_bit_pointer;
                    res.is_code <= 1'b1;
                end
                cra_pkg::CRA_MODE_REGISTER: begin
                    res.addr <= {11'h000, bank, req.reg_field};
                end
                cra_pkg::CRA_MODE_SPECIFIC: begin
                    res.is_value <= 1'b1;
                    case (req.imply)
                        cra_pkg::CRA_IMPLY_ACC: begin
                            res.value <= arith_main_operand;
                        end
                        cra_pkg::CRA_IMPLY_SECOND: begin
                            res.value <= second_operand_reg;
                        end
                        cra_pkg::CRA_IMPLY_POINTER_LOW: begin
                            res.value <= data_pointer_low;
                        end
                        cra_pkg::CRA_IMPLY_POINTER_HIGH: begin
                            res.value <= data_pointer_high;
                        end
                        default: res.value <= arith_main_operand;
                    endcase
                end
                cra_pkg::CRA_MODE_IMMEDIATE: begin
                    res.is_value <= 1'b1;
                    res.value <= req.imm_byte;
                    res.addr <= req.pc;
                    res.is_code <= 1'b1;
                end
                cra_pkg::CRA_MODE_INDEXED: begin
                    res.is_code <= 1'b1;
                    res.addr <= 16'(index_base
                        + {8'h00, arith_main_operand});
                end
                default: res.valid <= 1'b0;
            endcase
        end
    end

    // ***************************************************************
    // indexed jump target and state views
    // ***************************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            jump_target <= 16'h0000;
        end else if (jump_req) begin
            jump_target <= 16'(sixteen_bit_pointer
                + {8'h00, arith_main_operand});
        end
    end

    assign stack_top = stack_pointer;
    assign pointer_value = sixteen_bit_pointer;
endmodule // cra_regs

// >>> cra_regs_chk.sv
// checker: port properties of the register set
`timescale 1ns/10ps
module cra_regs_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input cra_pkg::cra_req_type req,
    input cra_pkg::cra_res_type res,
    input cra_pkg::cra_wr_type wr,
    input wire logic push,
    input wire logic pop,
    input cra_pkg::cra_alu_type alu,
    input wire logic bit_carry_we,
    input wire logic bit_carry,
    input wire logic jump_req,
    input wire logic [15:0] jump_target,
    input wire logic [7:0] status_word,
    input wire logic [7:0] stack_top,
    input wire logic [15:0] pointer_value
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // ***************************************************************
    // operand request steps
    // ***************************************************************
    sequence s_direct;
        req.valid && req.mode == cra_pkg::CRA_MODE_DIRECT;
    endsequence
    sequence s_direct_res;
        res.valid && res.addr[7:0] == $past(req.addr_field)
        && res.is_sfr == $past(req.addr_field[7]);
    endsequence
    a_reset_views: assert property (
        $fell(rst) |-> stack_top == 8'h07 && pointer_value == 16'h0000
        && status_word == 8'h00) else $error("views wrong after reset");
    a_push_incr: assert property (
        push |=> stack_top == $past(stack_top) + 8'h01)
        else $error("push did not advance stack");
    a_pop_decr: assert property (
        pop && !push |=> stack_top == $past(stack_top) - 8'h01)
        else $error("pop did not step stack back");
    a_parity_acc: assert property (
        alu.acc_we |=> status_word[0] == ^$past(alu.acc))
        else $error("parity does not follow accumulator");
    a_bit_carry: assert property (
        bit_carry_we |=> status_word[7] == $past(bit_carry))
        else $error("bit unit carry lost");
    a_bank_select: assert property (
        wr.valid && wr.is_sfr && wr.addr == 8'hD0
        |=> status_word[4:3] == $past(wr.data[4:3]))
        else $error("bank select not written");
    a_direct_mode: assert property (
        s_direct |=> s_direct_res) else $error("direct operand wrong");
    a_indir_wide: assert property (
        req.valid && req.mode == cra_pkg::CRA_MODE_INDIRECT16
        |=> res.is_code && res.addr == $past(pointer_value))
        else $error("wide indirect not from pointer");
    a_imm_value: assert property (
        req.valid && req.mode == cra_pkg::CRA_MODE_IMMEDIATE
        |=> res.is_value && res.value == $past(req.imm_byte))
        else $error("immediate value wrong");
    a_res_idle: assert property (
        !req.valid |=> !res.valid) else $error("answer without request");
    a_jump_hold: assert property (
        !jump_req |=> $stable(jump_target)) else $error("jump target moved");
endmodule // cra_regs_chk

bind cra_regs cra_regs_chk chk_u (.clk_sys(clk_sys), .rst(rst),
    .req(req), .res(res), .wr(wr), .push(push), .pop(pop), .alu(alu),
    .bit_carry_we(bit_carry_we), .bit_carry(bit_carry),
    .jump_req(jump_req), .jump_target(jump_target),
    .status_word(status_word), .stack_top(stack_top),
    .pointer_value(pointer_value));

// >>> testbench.sv
// testbench: directed scenarios for the register set
`timescale 1ns/10ps
module testbench;
    logic clk_sys;
    logic rst;
    cra_pkg::cra_req_type req;
    cra_pkg::cra_res_type res;
    cra_pkg::cra_wr_type wr;
    logic push;
    logic [7:0] push_data;
    logic pop;
    cra_pkg::cra_alu_type alu;
    logic bit_carry_we;
    logic bit_carry;
    logic [7:0] sfr_rd_addr;
    logic [7:0] sfr_rd_data;
    logic [7:0] ram_rd_addr;
    logic [7:0] ram_rd_data;
    logic jump_req;
    logic [15:0] jump_target;
    logic [7:0] status_word;
    logic [7:0] stack_top;
    logic [15:0] pointer_value;
    logic [7:0] rd;
    int err_count;
    int n_tests;
    logic [7:0] adr [6] = '{8'h81, 8'h82, 8'h83, 8'hD0, 8'hE0, 8'hF0};
    logic [7:0] pat [6] = '{8'h3C, 8'h5A, 8'hC3, 8'hE7, 8'h96, 8'h69};
    logic [7:0] acc_v [6] = '{8'h00, 8'h01, 8'h03, 8'h80, 8'hFE, 8'hFF};

    cra_regs dut_u (.clk_sys(clk_sys), .rst(rst), .req(req), .res(res),
        .wr(wr), .push(push), .push_data(push_data), .pop(pop), .alu(alu),
        .bit_carry_we(bit_carry_we), .bit_carry(bit_carry),
        .sfr_rd_addr(sfr_rd_addr), .sfr_rd_data(sfr_rd_data),
        .ram_rd_addr(ram_rd_addr), .ram_rd_data(ram_rd_data),
        .jump_req(jump_req), .jump_target(jump_target),
        .status_word(status_word), .stack_top(stack_top),
        .pointer_value(pointer_value));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // ***************************************************************
    // shared drivers, all but check entered at a falling edge
    // ***************************************************************
    task automatic check(input string what, input logic [15:0] seen,
            input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_byte(input logic s, input logic [7:0] a,
            input logic [7:0] d);
        @(negedge clk_sys);
        wr = '{1'b1, s, a, d};
        @(negedge clk_sys);
        wr = '0;
    endtask
    task automatic rd_byte(input logic s, input logic [7:0] a);
        @(negedge clk_sys);
        sfr_rd_addr = a;
        ram_rd_addr = a;
        @(negedge clk_sys);
        rd = s ? sfr_rd_data : ram_rd_data;
    endtask
    task automatic set_acc(input logic [7:0] d);
        @(negedge clk_sys);
        alu = '{acc_we: 1'b1, acc: d, default: '0};
        @(negedge clk_sys);
        alu = '0;
    endtask
    // one request; field doubles as address, register and immediate
    task automatic ask(input cra_pkg::cra_mode_type m, input logic [7:0] f,
            input logic [1:0] s);
        cra_pkg::cra_req_type r;
        r = '0;
        r.valid = 1'b1;
        r.mode = m;
        r.addr_field = f;
        r.reg_field = f[2:0];
        r.imm_byte = f;
        r.indir_src = s;
        r.use_pc_base = s[0];
        r.pc = 16'hFFF0;
        r.imply = cra_pkg::cra_imply_type'(s);
        @(negedge clk_sys);
        req = r;
        @(negedge clk_sys);
        req = '0;
    endtask
    // ***************************************************************
    // scenarios
    // ***************************************************************
    task automatic t_reset;
        for (int i = 0; i < 6; i++) begin
            rd_byte(1'b1, adr[i]);
            check("reset", 16'(rd), (i == 0) ? 16'h0007 : 16'h0000);
        end
        check("sp view", 16'(stack_top), 16'h0007);
        $display("test reset done");
    endtask
    task automatic t_sfr_rw;
        for (int i = 0; i < 6; i++) wr_byte(1'b1, adr[i], pat[i]);
        wr_byte(1'b1, 8'h84, 8'hFF);
        for (int i = 0; i < 6; i++) begin
            rd_byte(1'b1, adr[i]);
            check("reg rw", 16'(rd),
                16'((i == 3) ? 8'hE6 : pat[i]));
        end
        rd_byte(1'b1, 8'h84);
        check("unmapped", 16'(rd), 16'h0000);
        check("pointer", pointer_value, 16'hC35A);
        $display("test register access done");
    endtask
    task automatic t_parity;
        for (int i = 0; i < 6; i++) begin
            set_acc(acc_v[i]);
            check("parity", 16'(status_word[0]), 16'(^acc_v[i]));
            rd_byte(1'b1, 8'hE0);
            check("acc", 16'(rd), 16'(acc_v[i]));
        end
        $display("test parity done");
    endtask
    task automatic t_carry;
        @(negedge clk_sys);
        alu = '{carry_we: 1'b1, carry: 1'b1, aux_we: 1'b1, aux: 1'b1,
            range_we: 1'b1, range: 1'b1, default: '0};
        bit_carry_we = 1'b1;
        bit_carry = 1'b0;
        @(negedge clk_sys);
        alu = '0;
        bit_carry_we = 1'b0;
        check("flags", 16'(status_word & 8'hC4), 16'h0044);
        set_acc(8'h00);
        @(negedge clk_sys);
        alu = '{carry_we: 1'b1, carry: 1'b1, second_we: 1'b1,
            second: 8'hA5, default: '0};
        @(negedge clk_sys);
        alu = '0;
        check("carry", 16'(status_word[7]), 16'h0001);
        rd_byte(1'b1, 8'hF0);
        check("second", 16'(rd), 16'h00A5);
        $display("test carry done");
    endtask
    task automatic t_stack;
        wr_byte(1'b1, 8'h81, 8'h2F);
        @(negedge clk_sys);
        push = 1'b1;
        push_data = 8'hA5;
        @(negedge clk_sys);
        push_data = 8'h5B;
        @(negedge clk_sys);
        push = 1'b0;
        check("sp push", 16'(stack_top), 16'h0031);
        rd_byte(1'b0, 8'h30);
        check("push one", 16'(rd), 16'h00A5);
        rd_byte(1'b0, 8'h31);
        check("push two", 16'(rd), 16'h005B);
        ask(cra_pkg::CRA_MODE_INDIRECT8, 8'h00, cra_pkg::INDEX_STACK);
        check("stack ind", res.addr, 16'h0031);
        @(negedge clk_sys);
        pop = 1'b1;
        @(negedge clk_sys);
        pop = 1'b0;
        check("sp pop", 16'(stack_top), 16'h0030);
        $display("test stack done");
    endtask
    task automatic t_banks;
        for (int b = 0; b < 4; b++) begin
            wr_byte(1'b1, 8'hD0, 8'(b << 3));
            wr_byte(1'b0, 8'(b * 8), 8'(8'h20 + b));
            wr_byte(1'b0, 8'(b * 8 + 1), 8'(8'h90 + b));
            ask(cra_pkg::CRA_MODE_REGISTER, 8'h06, 2'h0);
            check("reg mode", res.addr, 16'(b * 8 + 6));
            ask(cra_pkg::CRA_MODE_INDIRECT8, 8'h00, cra_pkg::INDEX_WORK_ONE);
            check("ind one", {res.is_sfr, res.addr[14:0]},
                16'(8'h90 + b));
            ask(cra_pkg::CRA_MODE_INDIRECT8, 8'h00, cra_pkg::INDEX_WORK_ZERO);
            check("ind zero", res.addr, 16'(8'h20 + b));
        end
        $display("test banks done");
    endtask
    task automatic t_modes;
        ask(cra_pkg::CRA_MODE_DIRECT, 8'h45, 2'h0);
        check("dir ram", {res.is_sfr, res.addr[14:0]}, 16'h0045);
        ask(cra_pkg::CRA_MODE_DIRECT, 8'h81, 2'h0);
        check("dir sfr", {res.is_sfr, res.addr[14:0]}, 16'h8081);
        ask(cra_pkg::CRA_MODE_IMMEDIATE, 8'h5A, 2'h0);
        check("imm", {7'h00, res.is_value, res.value}, 16'h015A);
        ask(cra_pkg::CRA_MODE_SPECIFIC, 8'h00, 2'h1);
        check("implied", 16'(res.value), 16'h00A5);
        wr_byte(1'b1, 8'h82, 8'hFF);
        wr_byte(1'b1, 8'h83, 8'h12);
        ask(cra_pkg::CRA_MODE_INDIRECT16, 8'h00, 2'h0);
        check("ind16", {res.is_code, res.addr[14:0]}, 16'h92FF);
        set_acc(8'hF0);
        ask(cra_pkg::CRA_MODE_SPECIFIC, 8'h00, 2'h0);
        check("implied acc", 16'(res.value), 16'h00F0);
        ask(cra_pkg::CRA_MODE_SPECIFIC, 8'h00, 2'h2);
        check("implied lo", 16'(res.value), 16'h00FF);
        ask(cra_pkg::CRA_MODE_SPECIFIC, 8'h00, 2'h3);
        check("implied hi", 16'(res.value), 16'h0012);
        ask(cra_pkg::CRA_MODE_INDEXED, 8'h00, 2'h0);
        check("idx ptr", {res.is_code, res.addr[14:0]}, 16'h93EF);
        ask(cra_pkg::CRA_MODE_INDEXED, 8'h00, 2'h1);
        check("idx pc", res.addr, 16'h00E0);
        @(negedge clk_sys);
        jump_req = 1'b1;
        @(negedge clk_sys);
        jump_req = 1'b0;
        set_acc(8'h01);
        check("jump", jump_target, 16'h13EF);
        $display("test modes done");
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        {req, wr, alu} = '0;
        {push, push_data, pop, bit_carry_we, bit_carry, jump_req} = '0;
        {sfr_rd_addr, ram_rd_addr} = '0;
        repeat (6) @(negedge clk_sys);
        rst = 1'b0;
        t_reset();
        t_sfr_rw();
        t_parity();
        t_carry();
        t_stack();
        t_banks();
        t_modes();
        results();
    end
    initial begin
        repeat (3000) @(posedge clk_sys);
        err_count++;
        results();
    end
endmodule // testbench
